// ==== common/fpes_params.svh ====
/*
 * constants of the flash page erase selector: register indices and byte
 * addresses, field positions, reset values and array geometry.
 * assumes it is included by its bare name; definitions only.
 */
// Behaviour
// - flash is split into 512-byte pages; a page is the least erasable region
// - each page holds 8 rows of 64 bytes
// - the high sector at the top has its own write and erase permission
// - the first 2 bytes of flash are option bytes, not program storage
// - the page select register picks any one of 128 pages for erase
// - page erase writes FFH to every byte whose address[15:9] equals the page, except the option bytes while opt_en is clear
// - page index is register bits 6:0 and maps onto address bits 15:9
`ifndef FPES_PARAMS_SVH
`define FPES_PARAMS_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define FPES_PAGE_BYTES     512
`define FPES_ROWS           8
`define FPES_ROW_BYTES      64
`define FPES_PAGES          128
`define FPES_OPT_BYTES      16'h0002
`define FPES_ERASED         8'hFF
`define FPES_HS_FIRST_PAGE  7'h70

// ****************************************************************
// register map: index, byte address is four times the index
// ****************************************************************
`define FPES_IDX_SEL        12'hFF9
`define FPES_IDX_CTRL       12'hFFA
`define FPES_IDX_STAT       12'hFFB
`define FPES_ADDR_SEL       16'h3FE4
`define FPES_ADDR_CTRL      16'h3FE8
`define FPES_ADDR_STAT      16'h3FEC

// ****************************************************************
// fields and reset values
// ****************************************************************
`define FPES_SEL_RST        8'h00
`define FPES_PAGE_MSB       6
`define FPES_CTRL_START     0
`define FPES_CTRL_HS_EN     1
`define FPES_CTRL_OPT_EN    2
`define FPES_STAT_BUSY      0
`define FPES_STAT_DONE      1
`define FPES_STAT_REFUSED   2

`endif

// ==== common/fpes_pkg.sv ====
/*
 * types of the flash page erase selector.
 * assumes the constants header is compiled alongside.
 */
package fpes_pkg;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [2:0]
    {
        FPES_IDLE   = 3'b001,
        FPES_ERASE  = 3'b010,
        FPES_FINISH = 3'b100
    } fpes_state_t;

endpackage : fpes_pkg

// ==== core/fpes_sticky.sv ====
/*
 * sticky status flag: hardware sets, software clears.
 * assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module fpes_sticky
(
    // system
    input  wire logic clock,
    input  wire logic srst,
    // events
    input  wire logic set,
    input  wire logic clr,
    // flag
    output var  logic q
);
    logic next_q;

    // set wins over a clear in the same cycle
    always_comb
    begin
        next_q = set | (q & ~clr);
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            q <= 1'b0;
        else
            q <= next_q;
    end
endmodule : fpes_sticky
`default_nettype wire

// ==== core/fpes_walk.sv ====
/*
 * row and byte walker across one flash page.
 * assumes start and step never rise together.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpes_params.svh"
module fpes_walk
#(
    parameter  int ROWS      = `FPES_ROWS,
    parameter  int ROW_BYTES = `FPES_ROW_BYTES,
    localparam int RW        = $clog2(ROWS),
    localparam int CW        = $clog2(ROW_BYTES)
)
(
    // system
    input  wire logic          clock,
    input  wire logic          srst,
    // control
    input  wire logic          start,
    input  wire logic          step,
    // position
    output var  logic [RW-1:0] row,
    output var  logic [CW-1:0] col,
    output var  logic          last
);
    logic [RW-1:0] next_row;
    logic [CW-1:0] next_col;

    always_comb
    begin
        next_row = row;
        next_col = col;
        last     = step && (row == RW'(ROWS - 1)) && (col == CW'(ROW_BYTES - 1));
        if (start)
        begin
            next_row = '0;
            next_col = '0;
        end
        else if (step)
        begin
            if (col == CW'(ROW_BYTES - 1))
            begin
                next_col = '0;
                next_row = row + RW'(1);
            end
            else
                next_col = col + CW'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            row <= '0;
            col <= '0;
        end
        else
        begin
            row <= next_row;
            col <= next_col;
        end
    end
endmodule : fpes_walk
`default_nettype wire

// ==== core/fpes_flash_page_erase_select.sv ====
/*
 * flash page erase selector: avalon-mm register slave and a sequencer
 * that writes the erased value over every byte of the chosen page except the option bytes while opt_en is clear.
 * assumes a flash write port that accepts one byte per clock, and a
 * single 40 MHz clock with synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpes_params.svh"
module fpes_flash_page_erase_select
    import fpes_pkg::*;
#(
    parameter logic [6:0] HS_FIRST_PAGE = `FPES_HS_FIRST_PAGE
)
(
    // system
    input  wire logic        clock,
    input  wire logic        srst,
    // avalon-mm slave
    input  wire logic [15:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output var  logic [31:0] readdata,
    output var  logic        waitrequest,
    // flash write port
    output var  logic [15:0] flash_addr,
    output var  logic [7:0]  flash_wdata,
    output var  logic        flash_we
);
    // ****************************************************************
    // declarations
    // ****************************************************************
    fpes_state_t state;
    fpes_state_t next_state;
    logic [7:0]  flash_erase_target_select;
    logic [7:0]  next_flash_erase_target_select;
    logic        hs_en;
    logic        next_hs_en;
    logic        opt_en;
    logic        next_opt_en;
    logic [6:0]  erase_page;
    logic [6:0]  next_erase_page;
    logic [31:0] next_readdata;
    logic        next_waitrequest;
    logic [15:0] next_flash_addr;
    logic [7:0]  next_flash_wdata;
    logic        next_flash_we;
    logic        wr_go;
    logic        start_req;
    logic        done_clr;
    logic        refused_clr;
    logic        go_erase;
    logic        refuse;
    logic        hs_page;
    logic        done;
    logic        refused;
    logic        busy;
    logic [2:0]  row;
    logic [5:0]  col;
    logic        walk_last;
    logic [15:0] walk_addr;

    // ****************************************************************
    // avalon slave: one wait cycle, answer when waitrequest falls
    // ****************************************************************
    assign wr_go = write && !waitrequest;
    assign busy  = (state != FPES_IDLE);

    always_comb
    begin
        next_waitrequest = !((read || write) && waitrequest);
        next_readdata    = readdata;
        if (read && waitrequest)
        begin
            next_readdata = 32'h0000_0000;
            case (address)
                `FPES_ADDR_SEL:  next_readdata[7:0] = flash_erase_target_select;
                `FPES_ADDR_CTRL:
                begin
                    next_readdata[`FPES_CTRL_HS_EN]  = hs_en;
                    next_readdata[`FPES_CTRL_OPT_EN] = opt_en;
                end
                `FPES_ADDR_STAT:
                begin
                    next_readdata[`FPES_STAT_BUSY]    = busy;
                    next_readdata[`FPES_STAT_DONE]    = done;
                    next_readdata[`FPES_STAT_REFUSED] = refused;
                end
                default:         next_readdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    // the target cannot move under a running erase; such writes are dropped
    always_comb
    begin
        next_flash_erase_target_select = flash_erase_target_select;
        next_hs_en  = hs_en;
        next_opt_en = opt_en;
        start_req   = 1'b0;
        done_clr    = 1'b0;
        refused_clr = 1'b0;
        if (wr_go && byteenable[0])
        begin
            case (address)
                `FPES_ADDR_SEL:
                begin
                    if (!busy)
                        next_flash_erase_target_select = writedata[7:0];
                end
                `FPES_ADDR_CTRL:
                begin
                    next_hs_en  = writedata[`FPES_CTRL_HS_EN];
                    next_opt_en = writedata[`FPES_CTRL_OPT_EN];
                    start_req   = writedata[`FPES_CTRL_START];
                end
                `FPES_ADDR_STAT:
                begin
                    done_clr    = writedata[`FPES_STAT_DONE];
                    refused_clr = writedata[`FPES_STAT_REFUSED];
                end
                default:
                begin
                    start_req = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            waitrequest               <= 1'b1;
            readdata                  <= 32'h0000_0000;
            flash_erase_target_select <= `FPES_SEL_RST;
            hs_en                     <= 1'b0;
            opt_en                    <= 1'b0;
        end
        else
        begin
            waitrequest               <= next_waitrequest;
            readdata                  <= next_readdata;
            flash_erase_target_select <= next_flash_erase_target_select;
            hs_en                     <= next_hs_en;
            opt_en                    <= next_opt_en;
        end
    end

    // ****************************************************************
    // erase sequencer
    // ****************************************************************
    assign hs_page = flash_erase_target_select[`FPES_PAGE_MSB:0] >= HS_FIRST_PAGE;

    always_comb
    begin
        next_state      = state;
        next_erase_page = erase_page;
        go_erase        = 1'b0;
        refuse          = 1'b0;
        case (state)
            FPES_IDLE:
            begin
                if (start_req)
                begin
                    if (hs_page && !hs_en)
                        refuse = 1'b1;
                    else
                    begin
                        go_erase        = 1'b1;
                        next_erase_page = flash_erase_target_select[`FPES_PAGE_MSB:0];
                        next_state      = FPES_ERASE;
                    end
                end
            end
            FPES_ERASE:
            begin
                if (walk_last)
                    next_state = FPES_FINISH;
            end
            FPES_FINISH:
            begin
                next_state = FPES_IDLE;
            end
            default:
            begin
                next_state = FPES_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state      <= FPES_IDLE;
            erase_page <= 7'h00;
        end
        else
        begin
            state      <= next_state;
            erase_page <= next_erase_page;
        end
    end

    fpes_walk
    #(
        .ROWS      (`FPES_ROWS),
        .ROW_BYTES (`FPES_ROW_BYTES)
    )
    u_walk
    (
        .clock (clock),
        .srst  (srst),
        .start (go_erase),
        .step  (state == FPES_ERASE),
        .row   (row),
        .col   (col),
        .last  (walk_last)
    );

    fpes_sticky u_done
    (
        .clock (clock),
        .srst  (srst),
        .set   (state == FPES_FINISH),
        .clr   (done_clr),
        .q     (done)
    );

    fpes_sticky u_refused
    (
        .clock (clock),
        .srst  (srst),
        .set   (refuse),
        .clr   (refused_clr),
        .q     (refused)
    );

    // ****************************************************************
    // flash write port
    // ****************************************************************
    // option bytes survive a page 0 erase unless software opts in
    assign walk_addr = {erase_page, row, col};

    always_comb
    begin
        next_flash_addr  = walk_addr;
        next_flash_wdata = `FPES_ERASED;
        next_flash_we    = (state == FPES_ERASE) &&
                           !((walk_addr < `FPES_OPT_BYTES) && !opt_en);
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            flash_addr  <= 16'h0000;
            flash_wdata <= 8'h00;
            flash_we    <= 1'b0;
        end
        else
        begin
            flash_addr  <= next_flash_addr;
            flash_wdata <= next_flash_wdata;
            flash_we    <= next_flash_we;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [9:0] cyc_cnt;
    logic       hs_ok;

    always_ff @(posedge clock)
    begin
        if (srst || go_erase)
        begin
            cyc_cnt <= 10'h000;
            hs_ok   <= hs_en;
        end
        else if (state == FPES_ERASE)
            cyc_cnt <= cyc_cnt + 10'h001;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_start_ok;
        start_req && (state == FPES_IDLE) && !(hs_page && !hs_en);
    endsequence

    sequence s_start_hs_blocked;
        start_req && (state == FPES_IDLE) && hs_page && !hs_en;
    endsequence

    a_page_length: assert property (walk_last |-> cyc_cnt == 10'(`FPES_PAGE_BYTES - 1))
        else $error("erase did not cover exactly one page");
    a_row_layout: assert property (walk_last |=> flash_addr[8:0] == 9'h1FF)
        else $error("page did not end at last byte of last row");
    a_addr_ascend: assert property (flash_we && $past(flash_we)
                                    |-> flash_addr == $past(flash_addr) + 16'h0001)
        else $error("erase addresses not consecutive");
    a_hs_refused: assert property (s_start_hs_blocked |=> !busy && refused)
        else $error("high sector erase started without enable");
    a_opt_kept: assert property (flash_we && !opt_en |-> flash_addr >= `FPES_OPT_BYTES)
        else $error("option byte erased without opt-in");
    a_erase_starts: assert property (s_start_ok |=> busy)
        else $error("selected page erase did not start");
    a_erase_bound: assert property (busy |-> cyc_cnt <= 10'(`FPES_PAGE_BYTES))
        else $error("erase ran past one page");
    a_erase_len: assert property (walk_last |=> state == FPES_FINISH ##1 done)
        else $error("erase did not finish after the last byte");
    a_erased_value: assert property (flash_we |-> flash_wdata == `FPES_ERASED
                                     && flash_addr[15:9] == $past(erase_page))
        else $error("erase wrote wrong value or page");
    a_sel_maps: assert property (s_start_ok |=> erase_page == $past(flash_erase_target_select[6:0]))
        else $error("page index not taken from select bits");
    a_hs_guard: assert property (flash_we && flash_addr[15:9] >= HS_FIRST_PAGE |-> hs_ok)
        else $error("high sector written without enable");
endmodule : fpes_flash_page_erase_select
`default_nettype wire

// ==== verif/tb_top.sv ====
/*
 * self-checking bench for the flash page erase selector: register
 * access over avalon-mm and a queue model of each page erase.
 * assumes the constants header is on the include path and that the
 * selector answers every request within a few cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpes_params.svh"
module tb_top;

    // ****************************************************************
    // signals and model state
    // ****************************************************************
    logic        clock;
    logic        srst;
    logic [15:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [15:0] flash_addr;
    logic [7:0]  flash_wdata;
    logic        flash_we;
    int          errors;
    int          tests_run;
    int          exp_q[$];

    fpes_flash_page_erase_select #(.HS_FIRST_PAGE(7'h70)) uut
    (
        .clock       (clock),
        .srst        (srst),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .flash_addr  (flash_addr),
        .flash_wdata (flash_wdata),
        .flash_we    (flash_we)
    );

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task conclude;
        $display("counts: %0d checks, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // one avalon transfer; the gap cycle at entry keeps strobes single-driven
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clock);
        address   <= a;
        writedata <= d;
        if (wr)
            write <= 1'b1;
        else
            read <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
            check("bus answer", 32'h0, 32'h1);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    // every write strobe must match the head of the model's address queue
    always @(posedge clock)
    begin
        if (flash_we === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("unexpected flash write", 32'h0, {16'h0, flash_addr});
            else
                check("erase address", exp_q.pop_front(), {16'h0, flash_addr});
            check("erase data", 32'h0000_00FF, {24'h0, flash_wdata});
        end
    end

    task automatic erase(input logic [6:0] pg, input logic hs, input logic opt);
        logic [31:0] q;
        int          n;
        logic        refuse;
        refuse = (pg >= 7'h70) && !hs;
        bus(1'b1, `FPES_ADDR_SEL, {25'h0, pg}, q);
        // model: 8 rows of 64 ascending bytes, option bytes skipped while opt is clear
        if (!refuse)
            for (n = 0; n < 512; n++)
                if (opt || (pg * 512 + n) > 1)
                    exp_q.push_back(pg * 512 + n);
        bus(1'b1, `FPES_ADDR_CTRL, {29'h0, opt, hs, 1'b0}, q);
        bus(1'b1, `FPES_ADDR_CTRL, {29'h0, opt, hs, 1'b1}, q);
        bus(1'b0, `FPES_ADDR_STAT, 32'h0, q);
        if (refuse)
            check("refused status", 32'h4, q);
        else
        begin
            check("busy at start", 32'h1, {31'h0, q[0]});
            bus(1'b1, `FPES_ADDR_SEL, {25'h0, pg ^ 7'h01}, q);
            n = 0;
            do
            begin
                bus(1'b0, `FPES_ADDR_STAT, 32'h0, q);
                n++;
            end
            while (q[0] !== 1'b0 && n < 400);
            check("done status", 32'h2, q);
        end
        check("bytes left in model", 32'h0, exp_q.size());
        bus(1'b0, `FPES_ADDR_SEL, 32'h0, q);
        check("select held", {25'h0, pg}, q);
        bus(1'b0, `FPES_ADDR_CTRL, 32'h0, q);
        check("ctrl readback", {29'h0, opt, hs, 1'b0}, q);
        bus(1'b1, `FPES_ADDR_STAT, 32'h6, q);
        bus(1'b0, `FPES_ADDR_STAT, 32'h0, q);
        check("status cleared", 32'h0, q);
        exp_q.delete();
        $display("test erase page %h hs %b opt %b done", pg, hs, opt);
    endtask : erase

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin : main
        logic [31:0] q;
        logic [31:0] v;
        logic [15:0] regs[4];
        logic [6:0]  pgs[10];
        logic [9:0]  hss;
        logic [9:0]  opts;
        srst       = 1'b1;
        address    = 16'h0;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0;
        byteenable = 4'hF;
        errors     = 0;
        tests_run  = 0;
        regs = '{`FPES_ADDR_SEL, `FPES_ADDR_CTRL, `FPES_ADDR_STAT, 16'h3FF0};
        void'($urandom(46));
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        check("idle waitrequest", 32'h1, {31'h0, waitrequest});
        foreach (regs[i])
        begin
            bus(1'b0, regs[i], 32'h0, q);
            check("reset value", 32'h0, q);
        end
        $display("test reset values done");

        // unmapped and byte-disabled writes must leave select alone
        bus(1'b1, 16'h3FF0, 32'h0000_005A, q);
        byteenable <= 4'hE;
        bus(1'b1, `FPES_ADDR_SEL, 32'h0000_0033, q);
        byteenable <= 4'hF;
        bus(1'b0, `FPES_ADDR_SEL, 32'h0, q);
        check("select untouched", 32'h0, q);
        for (int i = 0; i < 8; i++)
        begin
            v = $urandom() & 32'hFFFF_FF7F;
            bus(1'b1, `FPES_ADDR_SEL, v, q);
            bus(1'b0, `FPES_ADDR_SEL, 32'h0, q);
            check("select readback", {24'h0, v[7:0]}, q);
        end
        $display("test select register done");

        pgs  = '{7'h00, 7'h00, 7'h01, 7'h6F, 7'h70, 7'h70, 7'h7F, 7'h7F,
                 7'($urandom_range(2, 110)), 7'($urandom_range(2, 110))};
        hss  = 10'b0101100000;
        opts = 10'b0100001001;
        for (int i = 0; i < 10; i++)
            erase(pgs[i], hss[9 - i], opts[9 - i]);
        conclude();
    end

    // ****************************************************************
    // watchdog: ten erases of about 550 cycles each fit well inside
    // ****************************************************************
    initial
    begin
        repeat (40000) @(posedge clock);
        errors++;
        conclude();
    end

endmodule : tb_top
`default_nettype wire
